// ### src/boot_loader_consts.svh
// Offsets, field positions, reset values and counts of the boot stream loader
`ifndef BOOT_LOADER_CONSTS_SVH
`define BOOT_LOADER_CONSTS_SVH

// Stream length in bits and serial clock divide in reference clock cycles
`define STREAM_BITS_DEF     256
`define SERIAL_CLK_DIV_DEF  256

// APB register map, byte addresses
`define APB_ADDR_W          8
`define ADDR_CTRL           8'h00
`define ADDR_STATUS         8'h04
`define ADDR_CONFIG         8'h08
`define ADDR_STREAM_HI      3'h2
`define CTRL_HOLD_BIT       0
`define CTRL_RESET          1'b0

// Bit positions inside the serial stream
`define SB_RATIO_LSB        5
`define SB_ENDIAN           8
`define SB_NBW_LSB          9
`define SB_TIMER            11
`define SB_SYSID_LSB        16
`define SB_HALF             20
`define SB_XLATE            24
`define SB_RSV_TOP_LSB      27

// Translation buffer entry pairs
`define XLATE_PAIRS_SMALL   7'h30
`define XLATE_PAIRS_LARGE   7'h40

// Status register fields
`define ST_STATE_LSB        0
`define ST_LOADED_BIT       6
`define ST_RSV_BIT          7
`define ST_CNT_LSB          8

// Config register fields
`define CF_RATIO_LSB        0
`define CF_HALF_BIT         3
`define CF_X2_LSB           4
`define CF_END_BIT          9
`define CF_NBW_LSB          10
`define CF_TMR_BIT          12
`define CF_SYSID_LSB        13
`define CF_XLATE_BIT        15

`endif

// ### src/boot_loader_pkg.sv
// Types shared by the reset sequencer and boot stream loader
package boot_loader_pkg;
    typedef enum logic [5:0] {
        ST_OFF  = 6'h01,
        ST_LOAD = 6'h02,
        ST_COLD = 6'h04,
        ST_HOLD = 6'h08,
        ST_RUN  = 6'h10,
        ST_WARM = 6'h20
    } seq_state_e;
endpackage : boot_loader_pkg

// ### src/config_stream_store.sv
// Shift store for the serial boot stream with a registered word read port
`timescale 1ns/100ps
module config_stream_store #(
    parameter  int BITS  = 256,
    localparam int IDX_W = $clog2(BITS / 32)
) (
    input  logic             core_clk,
    input  logic             rst,
    input  logic             shift_en,
    input  logic             shift_bit,
    input  logic [IDX_W-1:0] rd_idx,
    output logic [31:0]      rd_word,
    output logic [31:0]      low_word
);
    logic [BITS-1:0] store_reg;
    logic [31:0]     rd_word_reg;

    generate
        if (BITS < 64 || (BITS % 32) != 0) begin : g_bad_bits
            $error("config_stream_store: BITS must be a multiple of 32, at least 64");
        end
    endgenerate

    // First bit in ends up at position 0
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            store_reg <= '0;
        end else if (shift_en) begin
            store_reg <= {shift_bit, store_reg[BITS-1:1]};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_word_reg <= 32'h0000_0000;
        end else begin
            rd_word_reg <= store_reg[32*rd_idx +: 32];
        end
    end

    assign rd_word  = rd_word_reg;
    assign low_word = store_reg[31:0];
endmodule : config_stream_store

// ### src/reset_and_boot_mode_loader.sv
// Reset sequencer and serial boot mode loader with APB register access
`timescale 1ns/100ps
`include "boot_loader_consts.svh"
module reset_and_boot_mode_loader #(
    parameter int STREAM_BITS = `STREAM_BITS_DEF,
    parameter int CLK_DIV     = `SERIAL_CLK_DIV_DEF
) (
    input  logic                   core_clk,
    input  logic                   rst,
    input  logic                   power_good,
    input  logic                   cold_reset_n,
    input  logic                   warm_reset_n,
    input  logic                   boot_serial_in,
    input  logic                   endian_pin,
    output logic                   boot_serial_clk,
    output logic                   core_clear,
    output logic                   core_run,
    output logic                   reset_exception,
    output logic                   soft_reset_exception,
    output logic                   sys_bus_drive_en,
    output logic                   config_valid,
    output logic [2:0]             core_clock_ratio,
    output logic                   half_ratio,
    output logic [4:0]             ratio_x2,
    output logic                   endian_mode_bit,
    output logic [1:0]             nb_write_mode,
    output logic                   timer_irq_route,
    output logic [1:0]             system_id,
    output logic [6:0]             joint_xlate_buffer_pairs,
    input  logic                   psel,
    input  logic                   penable,
    input  logic                   pwrite,
    input  logic [`APB_ADDR_W-1:0] paddr,
    input  logic [31:0]            pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    localparam int DIV_W = $clog2(CLK_DIV);
    localparam int CNT_W = $clog2(STREAM_BITS + 1);
    localparam int IDX_W = $clog2(STREAM_BITS / 32);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);
    localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CLK_DIV / 2 - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(STREAM_BITS);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(STREAM_BITS - 1);

    generate
        if (CLK_DIV < 4 || (CLK_DIV & (CLK_DIV - 1)) != 0) begin : g_bad_div
            $error("CLK_DIV must be a power of two, at least 4");
        end
        if (STREAM_BITS < 64 || STREAM_BITS > 256 || (STREAM_BITS % 32) != 0) begin : g_bad_bits
            $error("STREAM_BITS must be a multiple of 32 from 64 to 256");
        end
    endgenerate

    boot_loader_pkg::seq_state_e state_reg;
    boot_loader_pkg::seq_state_e state_next;
    logic [DIV_W-1:0] div_reg;
    logic             clk_reg;
    logic [CNT_W-1:0] sample_cnt_reg;
    logic             sample_now;
    logic             fields_load_reg;
    logic             valid_reg;
    logic             rsv_seen_reg;
    logic             hold_reg;
    logic             clear_reg;
    logic             run_reg;
    logic             rexc_reg;
    logic             sexc_reg;
    logic             drive_reg;
    logic [2:0]       ratio_reg;
    logic             half_reg;
    logic [4:0]       x2_reg;
    logic             end_cfg_reg;
    logic             end_reg;
    logic [1:0]       nbw_reg;
    logic             tmr_reg;
    logic [1:0]       sysid_reg;
    logic             xlate_reg;
    logic [6:0]       pairs_reg;
    logic [31:0]      prdata_reg;
    logic             pready_reg;
    logic             pslverr_reg;
    logic [31:0]      store_word;
    logic [31:0]      low_word;
    logic [31:0]      rd_data;
    logic             rd_err;
    logic             apb_first;
    logic             apb_done;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    function automatic logic reserved_index(input logic [CNT_W-1:0] idx);
        reserved_index = (idx == 0) || (idx == 18) || (idx == 19) ||
                         (idx >= 21 && idx <= 23) || (idx >= `SB_RSV_TOP_LSB);
    endfunction : reserved_index

    // free running divide from power good rise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
        end else if (!power_good) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + DIV_W'(1);
        end
    end

    // high while off, low at half period, high at wrap
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clk_reg <= 1'b1;
        end else if (!power_good || div_reg == DIV_LAST) begin
            clk_reg <= 1'b1;
        end else if (div_reg == DIV_HALF) begin
            clk_reg <= 1'b0;
        end
    end

    // sample just before each of the first STREAM_BITS rises in load, bit 0 first
    assign sample_now = power_good && (div_reg == DIV_LAST) &&
                        (state_reg == boot_loader_pkg::ST_LOAD) && (sample_cnt_reg != CNT_FULL);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_cnt_reg <= '0;
        end else if (state_reg == boot_loader_pkg::ST_OFF) begin
            sample_cnt_reg <= '0;
        end else if (sample_now) begin
            sample_cnt_reg <= sample_cnt_reg + CNT_W'(1);
        end
    end

    // flag any one seen in a reserved position
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rsv_seen_reg <= 1'b0;
        end else if (state_reg == boot_loader_pkg::ST_OFF) begin
            rsv_seen_reg <= 1'b0;
        end else if (sample_now && boot_serial_in && reserved_index(sample_cnt_reg)) begin
            rsv_seen_reg <= 1'b1;
        end
    end

    config_stream_store #(.BITS(STREAM_BITS)) u_store (
        .core_clk  (core_clk),
        .rst       (rst),
        .shift_en  (sample_now),
        .shift_bit (boot_serial_in),
        .rd_idx    (paddr[IDX_W+1:2]),
        .rd_word   (store_word),
        .low_word  (low_word)
    );

    // Sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            boot_loader_pkg::ST_OFF:  state_next = boot_loader_pkg::ST_LOAD;
            boot_loader_pkg::ST_LOAD: begin
                if (sample_cnt_reg == CNT_FULL) begin
                    state_next = boot_loader_pkg::ST_COLD;
                end
            end
            boot_loader_pkg::ST_COLD: begin
                if (cold_reset_n) begin
                    state_next = boot_loader_pkg::ST_HOLD;
                end
            end
            boot_loader_pkg::ST_HOLD, boot_loader_pkg::ST_WARM: begin
                if (warm_reset_n && !hold_reg) begin
                    state_next = boot_loader_pkg::ST_RUN;
                end
            end
            boot_loader_pkg::ST_RUN: begin
                if (!warm_reset_n) begin
                    state_next = boot_loader_pkg::ST_WARM;
                end
            end
            default: state_next = boot_loader_pkg::ST_OFF;
        endcase
        // cold reset after load restarts without reread
        if (!cold_reset_n && state_reg != boot_loader_pkg::ST_OFF &&
            state_reg != boot_loader_pkg::ST_LOAD) begin
            state_next = boot_loader_pkg::ST_COLD;
        end
        // dropping power good restarts the whole sequence
        if (!power_good) begin
            state_next = boot_loader_pkg::ST_OFF;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg <= boot_loader_pkg::ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // clear during cold phases, keep state through warm reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clear_reg <= 1'b1;
            run_reg   <= 1'b0;
            drive_reg <= 1'b0;
        end else begin
            clear_reg <= (state_next == boot_loader_pkg::ST_OFF) ||
                         (state_next == boot_loader_pkg::ST_LOAD) ||
                         (state_next == boot_loader_pkg::ST_COLD);
            run_reg   <= (state_next == boot_loader_pkg::ST_RUN);
            // pins stay undriven until released into run
            drive_reg <= (state_next == boot_loader_pkg::ST_RUN);
        end
    end

    // exception kind set by the phase being left
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rexc_reg <= 1'b0;
            sexc_reg <= 1'b0;
        end else begin
            rexc_reg <= (state_reg == boot_loader_pkg::ST_HOLD) &&
                        (state_next == boot_loader_pkg::ST_RUN);
            sexc_reg <= (state_reg == boot_loader_pkg::ST_WARM) &&
                        (state_next == boot_loader_pkg::ST_RUN);
        end
    end

    // latch fields one cycle after the final bit lands
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fields_load_reg <= 1'b0;
            valid_reg       <= 1'b0;
        end else begin
            fields_load_reg <= sample_now && (sample_cnt_reg == CNT_LAST);
            if (state_reg == boot_loader_pkg::ST_OFF) begin
                valid_reg <= 1'b0;
            end else if (fields_load_reg) begin
                valid_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ratio_reg   <= 3'h0;
            half_reg    <= 1'b0;
            x2_reg      <= 5'h04;
            end_cfg_reg <= 1'b0;
            nbw_reg     <= 2'h0;
            tmr_reg     <= 1'b0;
            sysid_reg   <= 2'h0;
            xlate_reg   <= 1'b0;
            pairs_reg   <= `XLATE_PAIRS_SMALL;
        end else if (fields_load_reg) begin
            ratio_reg <= low_word[`SB_RATIO_LSB +: 3];
            half_reg  <= low_word[`SB_HALF];
            if (low_word[`SB_HALF] && low_word[`SB_RATIO_LSB] &&
                low_word[`SB_RATIO_LSB +: 3] != 3'h1) begin
                x2_reg <= {2'h0, low_word[`SB_RATIO_LSB +: 3]} + 5'h02;
            end else begin
                x2_reg <= {1'b0, low_word[`SB_RATIO_LSB +: 3], 1'b0} + 5'h04;
            end
            end_cfg_reg <= low_word[`SB_ENDIAN];
            nbw_reg     <= low_word[`SB_NBW_LSB +: 2];
            tmr_reg     <= low_word[`SB_TIMER];
            sysid_reg   <= low_word[`SB_SYSID_LSB +: 2];
            xlate_reg   <= low_word[`SB_XLATE];
            pairs_reg   <= low_word[`SB_XLATE] ? `XLATE_PAIRS_LARGE : `XLATE_PAIRS_SMALL;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            end_reg <= 1'b0;
        end else begin
            end_reg <= end_cfg_reg | endian_pin;
        end
    end

    // APB slave: answer one cycle into the access phase
    assign apb_first = psel && penable && !pready_reg;
    assign apb_done  = psel && penable && pready_reg;

    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (paddr == `ADDR_CTRL) begin
            rd_data[`CTRL_HOLD_BIT] = hold_reg;
        end else if (paddr == `ADDR_STATUS) begin
            rd_data[`ST_STATE_LSB +: 6]  = state_reg;
            rd_data[`ST_LOADED_BIT]      = valid_reg;
            rd_data[`ST_RSV_BIT]         = rsv_seen_reg;
            rd_data[`ST_CNT_LSB +: CNT_W] = sample_cnt_reg;
        end else if (paddr == `ADDR_CONFIG) begin
            rd_data[`CF_RATIO_LSB +: 3] = ratio_reg;
            rd_data[`CF_HALF_BIT]       = half_reg;
            rd_data[`CF_X2_LSB +: 5]    = x2_reg;
            rd_data[`CF_END_BIT]        = end_reg;
            rd_data[`CF_NBW_LSB +: 2]   = nbw_reg;
            rd_data[`CF_TMR_BIT]        = tmr_reg;
            rd_data[`CF_SYSID_LSB +: 2] = sysid_reg;
            rd_data[`CF_XLATE_BIT]      = xlate_reg;
        end else if (paddr[7:5] == `ADDR_STREAM_HI && paddr[1:0] == 2'h0 &&
                     int'(paddr[4:2]) < STREAM_BITS / 32) begin
            rd_data = store_word;
        end else begin
            rd_err = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apb_first;
            if (apb_first) begin
                prdata_reg  <= (pwrite || rd_err) ? 32'h0000_0000 : rd_data;
                pslverr_reg <= rd_err;
            end else if (apb_done) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hold_reg <= `CTRL_RESET;
        end else if (apb_done && pwrite && paddr == `ADDR_CTRL) begin
            hold_reg <= pwdata[`CTRL_HOLD_BIT];
        end
    end

    // Checks on the sequencer and loader
    localparam int             CHK_W    = DIV_W + 1;
    localparam logic [DIV_W:0] GAP_LAST = CHK_W'(CLK_DIV - 1);
    localparam logic [DIV_W:0] GAP_FULL = CHK_W'(CLK_DIV);
    logic [DIV_W:0] gap_reg;
    logic [DIV_W:0] pg_cnt_reg;
    logic           clk_prev_reg;
    logic           seen_rise_reg;
    wire            rise_now = clk_reg && !clk_prev_reg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            gap_reg       <= '0;
            pg_cnt_reg    <= '0;
            clk_prev_reg  <= 1'b1;
            seen_rise_reg <= 1'b0;
        end else begin
            clk_prev_reg  <= clk_reg;
            gap_reg       <= (rise_now || !power_good) ? '0 : gap_reg + CHK_W'(1);
            // Cycles since power good rose, saturating after one period
            if (!power_good) begin
                pg_cnt_reg <= '0;
            end else if (pg_cnt_reg != GAP_FULL) begin
                pg_cnt_reg <= pg_cnt_reg + CHK_W'(1);
            end
            seen_rise_reg <= power_good && (seen_rise_reg || rise_now);
        end
    end

    sequence s_rise_due;
        power_good && pg_cnt_reg == GAP_LAST;
    endsequence

    a_clk_off_high:  assert property (!power_good |=> boot_serial_clk)
        else $error("serial clock not high while power is off");
    a_first_rise:    assert property (s_rise_due |=> $rose(boot_serial_clk))
        else $error("first serial clock rise not 256 cycles after power good");
    a_clk_period:    assert property (rise_now && seen_rise_reg && power_good |-> gap_reg == GAP_LAST)
        else $error("serial clock period is not 256 cycles");
    a_sample_limit:  assert property (sample_cnt_reg <= CNT_FULL)
        else $error("more stream bits sampled than the stream holds");
    a_warm_no_load:  assert property (state_reg == boot_loader_pkg::ST_WARM |=> $stable(sample_cnt_reg))
        else $error("stream sampled during warm reset");
    a_soft_exc:      assert property ($rose(soft_reset_exception) |-> $past(warm_reset_n) && !reset_exception)
        else $error("soft reset exception without warm reset release");
    a_cold_exc:      assert property (reset_exception |-> $past(state_reg == boot_loader_pkg::ST_HOLD) && core_run)
        else $error("reset exception not followed by run");
    a_bus_undriven:  assert property (!warm_reset_n |=> !sys_bus_drive_en)
        else $error("bus driven while warm reset held");
    a_cold_clears:   assert property (!cold_reset_n && power_good |=> core_clear && !core_run)
        else $error("state machines not cleared in cold reset");
    a_ratio_decode:  assert property ($rose(config_valid) |-> ratio_x2 >= 5'd4 && ratio_x2 <= 5'd18)
        else $error("clock ratio decode out of range");
    a_fields_stable: assert property (config_valid && $past(config_valid) |-> $stable(nb_write_mode) && $stable(system_id))
        else $error("config fields changed after load");

    assign boot_serial_clk          = clk_reg;
    assign core_clear               = clear_reg;
    assign core_run                 = run_reg;
    assign reset_exception          = rexc_reg;
    assign soft_reset_exception     = sexc_reg;
    assign sys_bus_drive_en         = drive_reg;
    assign config_valid             = valid_reg;
    assign core_clock_ratio         = ratio_reg;
    assign half_ratio               = half_reg;
    assign ratio_x2                 = x2_reg;
    assign endian_mode_bit          = end_reg;
    assign nb_write_mode            = nbw_reg;
    assign timer_irq_route          = tmr_reg;
    assign system_id                = sysid_reg;
    assign joint_xlate_buffer_pairs = pairs_reg;
    assign prdata                   = prdata_reg;
    assign pready                   = pready_reg;
    assign pslverr                  = pslverr_reg;
endmodule : reset_and_boot_mode_loader

// ### test/boot_source_model.sv
// Serial boot stream source on the far side of the loader
`timescale 1ns/100ps
module boot_source_model (
    input  logic         core_clk,
    input  logic         power_good,
    input  logic         boot_serial_clk,
    input  logic [255:0] stream,
    output logic         boot_serial_in
);
    logic prev_clk = 1'b1;
    logic flip     = 1'b0;
    int   idx      = 0;
    always @(posedge core_clk) begin
        prev_clk <= boot_serial_clk;
        flip     <= ~flip;
        if (!power_good) idx <= 0;
        else if (boot_serial_clk && !prev_clk) idx <= idx + 1;
    end
    // Reserved bits come zero in stream
    assign boot_serial_in = (idx < 256) ? stream[idx[7:0]] : flip;
endmodule : boot_source_model

// ### test/reset_and_boot_mode_loader_test.sv
// Self-checking bench for the reset sequencer and boot stream loader
`timescale 1ns/100ps
module reset_and_boot_mode_loader_test;
    localparam int DIV = 4;
    logic core_clk, rst, power_good, cold_reset_n, warm_reset_n, boot_serial_in, endian_pin;
    logic boot_serial_clk, core_clear, core_run, reset_exception, soft_reset_exception;
    logic sys_bus_drive_en, config_valid, half_ratio, endian_mode_bit, timer_irq_route;
    logic [2:0] core_clock_ratio;
    logic [4:0] ratio_x2;
    logic [1:0] nb_write_mode, system_id;
    logic [6:0] joint_xlate_buffer_pairs;
    logic psel, penable, pwrite, pready, pslverr, er, lo;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, r, seed;
    logic [255:0] stream, s;
    int error_cnt, n_checks, n;

    reset_and_boot_mode_loader #(.CLK_DIV(DIV)) u_dut (.*);
    boot_source_model u_src (.*);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic test_done;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            error_cnt++;
            $display("[ERR] t=%0t wait got=%h exp=%h", $time, k, lim);
            test_done();
        end
    endtask : tmo

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc

    function automatic logic sig(input int k);
        case (k)
            0: return config_valid;
            1: return reset_exception;
            default: return soft_reset_exception;
        endcase
    endfunction : sig

    task automatic wait_hi(input int k, input int lim);
        n = 0;
        while (sig(k) !== 1'b1 && n < lim) begin
            @(posedge core_clk);
            n++;
        end
        tmo(n, lim);
    endtask : wait_hi

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        tmo(n, 20);
    endtask : apb

    function automatic logic [31:0] xs();
        seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [31:0] cfg(input logic [255:0] v, input logic pin);
        int c, x2;
        c = int'(v[7:5]);
        x2 = (v[20] && c[0] && c >= 3) ? c + 2 : 2 * (c + 2);
        return {16'h0, v[24], v[17:16], v[11], v[10:9], v[8] | pin, 5'(x2), v[20], v[7:5]};
    endfunction : cfg

    initial begin
        rst = 1'b1; power_good = 1'b0; cold_reset_n = 1'b0; warm_reset_n = 1'b0;
        endian_pin = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; stream = '0; seed = 32'h0000D49B; error_cnt = 0; n_checks = 0;
        cyc(2);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            r = xs();
            s = '0;
            s[7:5] = 3'(i); s[20] = i[3]; s[8] = r[0]; s[11] = r[1];
            s[17:16] = r[3:2]; s[24] = r[4]; s[10:9] = (i % 3 == 0) ? 2'h0 : 2'(i % 3 + 1);
            // power good low for 64 cycles, both resets held
            power_good <= 1'b0; cold_reset_n <= 1'b0; warm_reset_n <= 1'b0;
            cyc(64);
            chk({boot_serial_clk, core_clear, sys_bus_drive_en}, 3'h6);
            // power good rises with cold reset held, bit 0 present
            stream <= s; endian_pin <= r[5]; power_good <= 1'b1;
            n = 0; lo = 1'b0;
            while (!(lo && boot_serial_clk === 1'b1) && n < 99) begin
                @(posedge core_clk);
                n++;
                if (boot_serial_clk === 1'b0) lo = 1'b1;
            end
            chk(32'(n), 32'(DIV + 1));
            wait_hi(0, 256 * DIV + 50);
            apb(1'b0, 8'h08, 32'h0); chk(rd, cfg(s, r[5]));
            chk({16'h0, joint_xlate_buffer_pairs == 7'h40, system_id, timer_irq_route,
                 nb_write_mode, endian_mode_bit, ratio_x2, half_ratio, core_clock_ratio},
                cfg(s, r[5]));
            chk(32'(joint_xlate_buffer_pairs), s[24] ? 32'h40 : 32'h30);
            apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h00010044);
            apb(1'b0, 8'h40, 32'h0); chk(rd, s[31:0]);
            // cold reset released on an edge once the stream is read
            cold_reset_n <= 1'b1;
            // warm reset held 64 cycles after cold release
            cyc(64);
            chk(32'(sys_bus_drive_en), 32'h0);
            warm_reset_n <= 1'b1;
            wait_hi(1, 20);
            cyc(1);
            chk({core_run, sys_bus_drive_en, core_clear}, 3'h6);
            $display("load %0d done", i);
        end
        apb(1'b0, 8'h80, 32'h0); chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, 8'h00, 32'h1); apb(1'b0, 8'h00, 32'h0); chk(rd, 32'h1);
        // warm reset asserted on an edge and held 64 cycles
        warm_reset_n <= 1'b0;
        cyc(64);
        warm_reset_n <= 1'b1;
        cyc(10);
        chk({core_run, sys_bus_drive_en, core_clear}, 3'h0);
        apb(1'b1, 8'h00, 32'h0);
        wait_hi(2, 20);
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h00010050);
        // cold restart with both resets asserted
        warm_reset_n <= 1'b0;
        cold_reset_n <= 1'b0;
        apb(1'b0, 8'h04, 32'h0); chk(rd, 32'h00010044);
        chk(32'(core_clear), 32'h1);
        // cold released on an edge, warm held 64 more cycles
        cold_reset_n <= 1'b1;
        cyc(64);
        warm_reset_n <= 1'b1;
        wait_hi(1, 20);
        $display("reset tests done");
        test_done();
    end
endmodule : reset_and_boot_mode_loader_test
